/* File: port_pin_function_select.sv */
// Operation
// - port four direction switches only as whole eight-bit group
// - port five pins each individually input or output
// - port six pins each individually input or output
// - port seven per pin: gpio, serial in/out/clock, async receive/transmit
// - port ten three pins: gpio; pins one and two also intermediate frequency counter inputs
// - band counter pin may also feed medium-wave counter; other feeds only mw
// - port twelve five pins per-bit direction; control mode carries network rx/tx
// - port thirteen output only, open drain, gpio per pin; pins zero and one also timer output
// - low-band osc input active only in HF/MF mode with mode bit 2 set
// - low-band pull-down bit zero keeps input inactive; software sets it first
// - high-band osc input active only in FM mode with mode bit 3 set
// - high-band pull-down bit zero keeps input inactive; software releases it
// - charge pump outputs carry phase comparison result
// - low level on reset pin is system reset
`timescale 1ns/10ps
`include "pin_mux_defines.svh"
module port_pin_function_select
    import pin_mux_pkg::*;
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // port 4
    input wire logic [7:0] P4_IN_I,
    input wire logic [7:0] P4_LATCH_I,
    input wire logic P4_DIR_OUT_I,
    output logic [7:0] P4_OUT_O,
    output logic [7:0] P4_OE_O,
    output logic [7:0] P4_RD_O,
    // port 5
    input wire logic [7:0] P5_IN_I,
    input wire logic [7:0] P5_LATCH_I,
    input wire logic [7:0] P5_DIR_OUT_I,
    output logic [7:0] P5_OUT_O,
    output logic [7:0] P5_OE_O,
    output logic [7:0] P5_RD_O,
    // port 6
    input wire logic [7:0] P6_IN_I,
    input wire logic [7:0] P6_LATCH_I,
    input wire logic [7:0] P6_DIR_OUT_I,
    output logic [7:0] P6_OUT_O,
    output logic [7:0] P6_OE_O,
    output logic [7:0] P6_RD_O,
    // port 7
    input wire logic [7:0] P7_IN_I,
    input wire logic [7:0] P7_LATCH_I,
    input wire logic [7:0] P7_DIR_OUT_I,
    input wire logic [7:0] P7_ALT_I,
    input wire logic SERIAL3_DATA_OUT_I,
    input wire logic SERIAL3_CLOCK_OUT_I,
    input wire logic SERIAL3_CLOCK_OE_I,
    input wire logic ASYNC_TRANSMIT_I,
    output logic [7:0] P7_OUT_O,
    output logic [7:0] P7_OE_O,
    output logic [7:0] P7_RD_O,
    output logic SERIAL3_DATA_IN_O,
    output logic SERIAL3_CLOCK_IN_O,
    output logic ASYNC_RECEIVE_O,
    // port 10
    input wire logic [2:0] P10_IN_I,
    input wire logic [2:0] P10_LATCH_I,
    input wire logic [2:0] P10_DIR_OUT_I,
    input wire logic [2:0] P10_ALT_I,
    input wire logic MW_SRC_BB_I,
    output logic [2:0] P10_OUT_O,
    output logic [2:0] P10_OE_O,
    output logic [2:0] P10_RD_O,
    output logic MW_IF_COUNTER_IN_O,
    output logic BB_IF_COUNTER_IN_O,
    // port 12
    input wire logic [4:0] P12_IN_I,
    input wire logic [4:0] P12_LATCH_I,
    input wire logic [4:0] P12_DIR_OUT_I,
    input wire logic [4:0] P12_ALT_I,
    input wire logic VNET_PRESENT_I,
    input wire logic VNET_TRANSMIT_I,
    output logic [4:0] P12_OUT_O,
    output logic [4:0] P12_OE_O,
    output logic [4:0] P12_RD_O,
    output logic VNET_RECEIVE_O,
    // port 13, open drain: oe high pulls the pin low
    input wire logic [7:0] P13_LATCH_I,
    input wire logic [7:0] P13_ALT_I,
    input wire logic TIMER8_OUT_A_I,
    input wire logic TIMER8_OUT_B_I,
    output logic [7:0] P13_OUT_O,
    output logic [7:0] P13_OE_O,
    // synthesizer
    input wire logic [7:0] SYNTH_MODE_SELECT_REG_I,
    input wire logic LOW_BAND_OSC_IN_I,
    input wire logic HIGH_BAND_OSC_IN_I,
    input wire logic PHASE_UP_I,
    input wire logic PHASE_DN_I,
    output logic LOW_BAND_OSC_O,
    output logic HIGH_BAND_OSC_O,
    output logic LOW_BAND_PULLDOWN_O,
    output logic HIGH_BAND_PULLDOWN_O,
    output logic [1:0] CHARGE_PUMP_OUT_A_O,
    output logic [1:0] CHARGE_PUMP_OUT_B_O,
    // system reset
    output logic SYS_RESET_O
);
    sync_if sif ();
    logic [7:0] p7_in_s;
    logic [2:0] p10_in_s;
    logic [4:0] p12_in_s;
    logic [7:0] p5_in_s;
    logic [7:0] p6_in_s;
    logic [7:0] p4_in_s;
    logic [1:0] osc_s;
    synth_mode_t mode;
    logic low_release;
    logic high_release;
    logic [7:0] p7_oe_nxt;
    logic [7:0] p7_out_nxt;
    logic [2:0] p10_oe_nxt;
    logic [4:0] p12_oe_nxt;
    logic [4:0] p12_out_nxt;
    logic [7:0] p13_drv_nxt;

    // gpio output: latch when driving, else zero
    function automatic logic [7:0] gpio_out(input logic [7:0] latch, input logic [7:0] oe);
        gpio_out = latch & oe;
    endfunction

    // pins arrive from outside: synchronise before use
    assign sif.raw = {P4_IN_I, P5_IN_I, P6_IN_I, P7_IN_I, P10_IN_I, P12_IN_I,
                      LOW_BAND_OSC_IN_I, HIGH_BAND_OSC_IN_I};
    pin_sync u_sync (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .sif(sif)
    );
    assign {p4_in_s, p5_in_s, p6_in_s, p7_in_s, p10_in_s, p12_in_s, osc_s} = sif.clean;

    assign mode = synth_mode_t'(SYNTH_MODE_SELECT_REG_I[`SYN_MODE_LSB +: `SYN_MODE_W]);
    assign low_release = SYNTH_MODE_SELECT_REG_I[`SYN_LOW_PD_BIT];
    assign high_release = SYNTH_MODE_SELECT_REG_I[`SYN_HIGH_PD_BIT];

    // port 7 steering
    always_comb begin
        p7_oe_nxt = P7_DIR_OUT_I & ~P7_ALT_I;
        p7_out_nxt = gpio_out(P7_LATCH_I, p7_oe_nxt);
        if (P7_ALT_I[`P7_SER_OUT]) begin
            p7_oe_nxt[`P7_SER_OUT] = 1'b1;
            p7_out_nxt[`P7_SER_OUT] = SERIAL3_DATA_OUT_I;
        end
        if (P7_ALT_I[`P7_SER_CLK]) begin
            p7_oe_nxt[`P7_SER_CLK] = SERIAL3_CLOCK_OE_I;
            p7_out_nxt[`P7_SER_CLK] = SERIAL3_CLOCK_OUT_I;
        end
        if (P7_ALT_I[`P7_ASY_TX]) begin
            p7_oe_nxt[`P7_ASY_TX] = 1'b1;
            p7_out_nxt[`P7_ASY_TX] = ASYNC_TRANSMIT_I;
        end
    end

    assign p10_oe_nxt = P10_DIR_OUT_I & ~P10_ALT_I;

    // port 12 steering
    always_comb begin
        p12_oe_nxt = P12_DIR_OUT_I;
        p12_out_nxt = P12_LATCH_I & P12_DIR_OUT_I;
        // network transmit, only where controller exists
        if (VNET_PRESENT_I && P12_ALT_I[`P12_TX_PIN]) begin
            p12_oe_nxt[`P12_TX_PIN] = 1'b1;
            p12_out_nxt[`P12_TX_PIN] = VNET_TRANSMIT_I;
        end
        if (VNET_PRESENT_I && P12_ALT_I[`P12_RX_PIN]) begin
            p12_oe_nxt[`P12_RX_PIN] = 1'b0;
            p12_out_nxt[`P12_RX_PIN] = 1'b0;
        end
    end

    // open drain: pull low when selected source is zero
    always_comb begin
        p13_drv_nxt = ~P13_LATCH_I & ~P13_ALT_I;
        if (P13_ALT_I[`P13_TMR_A]) begin
            p13_drv_nxt[`P13_TMR_A] = ~TIMER8_OUT_A_I;
        end
        if (P13_ALT_I[`P13_TMR_B]) begin
            p13_drv_nxt[`P13_TMR_B] = ~TIMER8_OUT_B_I;
        end
    end

    assign SYS_RESET_O = ~RST_B_I;

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            P4_OE_O <= `RST_ZERO8;
            P4_OUT_O <= `RST_ZERO8;
        end else begin
            P4_OE_O <= {`P4_W{P4_DIR_OUT_I}};
            P4_OUT_O <= gpio_out(P4_LATCH_I, {`P4_W{P4_DIR_OUT_I}});
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            P5_OE_O <= `RST_ZERO8;
            P5_OUT_O <= `RST_ZERO8;
            P6_OE_O <= `RST_ZERO8;
            P6_OUT_O <= `RST_ZERO8;
        end else begin
            P5_OE_O <= P5_DIR_OUT_I;
            P5_OUT_O <= gpio_out(P5_LATCH_I, P5_DIR_OUT_I);
            P6_OE_O <= P6_DIR_OUT_I;
            P6_OUT_O <= gpio_out(P6_LATCH_I, P6_DIR_OUT_I);
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            P7_OE_O <= `RST_ZERO8;
            P7_OUT_O <= `RST_ZERO8;
            SERIAL3_DATA_IN_O <= 1'b0;
            SERIAL3_CLOCK_IN_O <= 1'b0;
            ASYNC_RECEIVE_O <= 1'b1;
        end else begin
            P7_OE_O <= p7_oe_nxt;
            P7_OUT_O <= p7_out_nxt;
            SERIAL3_DATA_IN_O <= P7_ALT_I[`P7_SER_IN] & p7_in_s[`P7_SER_IN];
            SERIAL3_CLOCK_IN_O <= P7_ALT_I[`P7_SER_CLK] & p7_in_s[`P7_SER_CLK];
            // idle line high when deselected
            ASYNC_RECEIVE_O <= ~P7_ALT_I[`P7_ASY_RX] | p7_in_s[`P7_ASY_RX];
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            P10_OE_O <= `RST_ZERO3;
            P10_OUT_O <= `RST_ZERO3;
            MW_IF_COUNTER_IN_O <= 1'b0;
            BB_IF_COUNTER_IN_O <= 1'b0;
        end else begin
            P10_OE_O <= p10_oe_nxt;
            P10_OUT_O <= P10_LATCH_I & p10_oe_nxt;
            BB_IF_COUNTER_IN_O <= P10_ALT_I[`P10_BB_PIN] & p10_in_s[`P10_BB_PIN];
            // band pin may feed the medium-wave counter
            if (MW_SRC_BB_I) begin
                MW_IF_COUNTER_IN_O <= P10_ALT_I[`P10_BB_PIN] & p10_in_s[`P10_BB_PIN];
            end else begin
                MW_IF_COUNTER_IN_O <= P10_ALT_I[`P10_MW_PIN] & p10_in_s[`P10_MW_PIN];
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            P12_OE_O <= `RST_ZERO5;
            P12_OUT_O <= `RST_ZERO5;
            VNET_RECEIVE_O <= 1'b1;
        end else begin
            P12_OE_O <= p12_oe_nxt;
            P12_OUT_O <= p12_out_nxt;
            VNET_RECEIVE_O <= ~(VNET_PRESENT_I & P12_ALT_I[`P12_RX_PIN]) | p12_in_s[`P12_RX_PIN];
        end
    end

    // open drain stage; released at reset
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            P13_OE_O <= `RST_ZERO8;
        end else begin
            P13_OE_O <= p13_drv_nxt;
        end
    end
    assign P13_OUT_O = `RST_ZERO8;

    // read-back: synchronised pin levels
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            P4_RD_O <= `RST_ZERO8;
            P5_RD_O <= `RST_ZERO8;
            P6_RD_O <= `RST_ZERO8;
            P7_RD_O <= `RST_ZERO8;
            P10_RD_O <= `RST_ZERO3;
            P12_RD_O <= `RST_ZERO5;
        end else begin
            P4_RD_O <= p4_in_s;
            P5_RD_O <= p5_in_s;
            P6_RD_O <= p6_in_s;
            P7_RD_O <= p7_in_s;
            P10_RD_O <= p10_in_s;
            P12_RD_O <= p12_in_s;
        end
    end

    // low band active only in HF/MF and released
    // high band active only in FM and released
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            LOW_BAND_OSC_O <= 1'b0;
            HIGH_BAND_OSC_O <= 1'b0;
            LOW_BAND_PULLDOWN_O <= 1'b1;
            HIGH_BAND_PULLDOWN_O <= 1'b1;
        end else begin
            LOW_BAND_OSC_O <= ((mode == SYN_HF) || (mode == SYN_MF)) && low_release
                              && osc_s[`SYNC_OSC_LOW];
            HIGH_BAND_OSC_O <= (mode == SYN_FM) && high_release && osc_s[`SYNC_OSC_HIGH];
            LOW_BAND_PULLDOWN_O <= ~low_release;
            HIGH_BAND_PULLDOWN_O <= ~high_release;
        end
    end

    // phase result: {oe, level}; tri-state when no error
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            CHARGE_PUMP_OUT_A_O <= `RST_ZERO2;
            CHARGE_PUMP_OUT_B_O <= `RST_ZERO2;
        end else begin
            CHARGE_PUMP_OUT_A_O <= {PHASE_UP_I ^ PHASE_DN_I, PHASE_UP_I};
            CHARGE_PUMP_OUT_B_O <= {PHASE_UP_I ^ PHASE_DN_I, PHASE_UP_I};
        end
    end
endmodule // port_pin_function_select

/* File: pin_mux_defines.svh */
`ifndef PIN_MUX_DEFINES_SVH
`define PIN_MUX_DEFINES_SVH

// port widths
`define P4_W 8
`define P5_W 8
`define P6_W 8
`define P7_W 8
`define P10_W 3
`define P12_W 5
`define P13_W 8

// port 7 alternate bit positions
`define P7_SER_IN 0
`define P7_SER_OUT 1
`define P7_SER_CLK 2
`define P7_ASY_RX 4
`define P7_ASY_TX 5

// port 10 counter pins
`define P10_MW_PIN 1
`define P10_BB_PIN 2

// port 12 network pins
`define P12_TX_PIN 0
`define P12_RX_PIN 1

// port 13 timer pins
`define P13_TMR_A 0
`define P13_TMR_B 1

// synthesizer mode register bits
`define SYN_LOW_PD_BIT 2
`define SYN_HIGH_PD_BIT 3
`define SYN_MODE_LSB 0
`define SYN_MODE_W 2

// reset values
`define RST_ZERO8 8'h00
`define RST_ONES8 8'hFF
`define RST_ZERO2 2'h0
`define RST_ZERO3 3'h0
`define RST_ZERO5 5'h00
`define RST_ZERO42 42'h0

// oscillator bits at the low end of the synchroniser word
`define SYNC_OSC_LOW 1
`define SYNC_OSC_HIGH 0

`endif

/* File: pin_mux_pkg.sv */
package pin_mux_pkg;
    // synthesizer band selection, low two bits of the mode register
    typedef enum logic [1:0] {
        SYN_OFF = 2'h0,
        SYN_HF  = 2'h1,
        SYN_MF  = 2'h2,
        SYN_FM  = 2'h3
    } synth_mode_t;
endpackage

/* File: sync_if.sv */
`timescale 1ns/10ps
interface sync_if;
    logic [41:0] raw;
    logic [41:0] clean;
    modport src (output raw, input clean);
    modport snk (input raw, output clean);
endinterface

/* File: pin_sync.sv */
`timescale 1ns/10ps
`include "pin_mux_defines.svh"
module pin_sync (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // pins in, synchronised out
    sync_if.snk sif
);
    logic [41:0] meta_r;
    logic [41:0] sync_r;

    // two stages; first stage read only by second
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_r <= `RST_ZERO42;
            sync_r <= `RST_ZERO42;
        end else begin
            meta_r <= sif.raw;
            sync_r <= meta_r;
        end
    end

    assign sif.clean = sync_r;
endmodule // pin_sync

/* File: pin_board.sv */
`timescale 1ns/10ps
module pin_board (
    // drive from the block
    input wire logic [39:0] oe_i,
    input wire logic [39:0] out_i,
    // board level where released
    input wire logic [39:0] ext_i,
    // resolved pin levels
    output logic [39:0] pin_o
);
    // a released pin shows a fresh board level, never the last driven one
    assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule // pin_board

/* File: port_pin_function_select_monitor.sv */
`timescale 1ns/10ps
module port_pin_function_select_monitor
    import pin_mux_pkg::*;
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // watched ports
    input wire logic P4_DIR_OUT_I,
    input wire logic [7:0] P4_OE_O,
    input wire logic [7:0] P5_DIR_OUT_I,
    input wire logic [7:0] P5_OE_O,
    input wire logic [2:0] P10_ALT_I,
    input wire logic [2:0] P10_OE_O,
    input wire logic [4:0] P12_DIR_OUT_I,
    input wire logic VNET_PRESENT_I,
    input wire logic [4:0] P12_OE_O,
    input wire logic [7:0] P13_ALT_I,
    input wire logic TIMER8_OUT_A_I,
    input wire logic [7:0] P13_OUT_O,
    input wire logic [7:0] P13_OE_O,
    input wire logic [7:0] SYNTH_MODE_SELECT_REG_I,
    input wire logic LOW_BAND_PULLDOWN_O,
    input wire logic HIGH_BAND_PULLDOWN_O,
    input wire logic PHASE_UP_I,
    input wire logic PHASE_DN_I,
    input wire logic [1:0] CHARGE_PUMP_OUT_A_O,
    input wire logic SYS_RESET_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);

    a_p4_group: assert property (P4_OE_O == {8{P4_OE_O[0]}})
        else $error("port 4 direction split");
    a_p4_dir: assert property ($past(RST_B_I) |-> P4_OE_O == {8{$past(P4_DIR_OUT_I)}})
        else $error("port 4 direction late");
    a_p5_dir: assert property ($past(RST_B_I) |-> P5_OE_O == $past(P5_DIR_OUT_I))
        else $error("port 5 direction wrong");
    a_p10_alt_input: assert property ($past(RST_B_I) |-> (P10_OE_O & $past(P10_ALT_I)) == 3'h0)
        else $error("port 10 counter pin driven");
    a_p12_refused: assert property ($past(RST_B_I) && !$past(VNET_PRESENT_I)
        |-> P12_OE_O == $past(P12_DIR_OUT_I))
        else $error("port 12 alt not ignored");
    a_p13_open_drain: assert property (P13_OUT_O == 8'h00)
        else $error("port 13 drives high");
    a_p13_timer: assert property ($past(RST_B_I) && $past(P13_ALT_I[0])
        |-> P13_OE_O[0] == !$past(TIMER8_OUT_A_I))
        else $error("port 13 timer output wrong");
    a_low_pulldown: assert property ($past(RST_B_I)
        |-> LOW_BAND_PULLDOWN_O == !$past(SYNTH_MODE_SELECT_REG_I[2]))
        else $error("low band pull-down wrong");
    a_high_pulldown: assert property ($past(RST_B_I)
        |-> HIGH_BAND_PULLDOWN_O == !$past(SYNTH_MODE_SELECT_REG_I[3]))
        else $error("high band pull-down wrong");
    a_pump_result: assert property ($past(RST_B_I) |-> CHARGE_PUMP_OUT_A_O ==
        {$past(PHASE_UP_I) ^ $past(PHASE_DN_I), $past(PHASE_UP_I)})
        else $error("charge pump output wrong");
    a_sys_reset: assert property (disable iff (1'b0) SYS_RESET_O == !RST_B_I)
        else $error("system reset not following pin");
    a_reset_inputs: assert property ($rose(RST_B_I)
        |-> {P4_OE_O, P5_OE_O, P10_OE_O, P12_OE_O} == 24'h000000)
        else $error("pin driven after reset");
endmodule // port_pin_function_select_monitor

bind port_pin_function_select port_pin_function_select_monitor mon (
    .CLK_I(CLK_I), .RST_B_I(RST_B_I), .P4_DIR_OUT_I(P4_DIR_OUT_I), .P4_OE_O(P4_OE_O),
    .P5_DIR_OUT_I(P5_DIR_OUT_I), .P5_OE_O(P5_OE_O), .P10_ALT_I(P10_ALT_I), .P10_OE_O(P10_OE_O),
    .P12_DIR_OUT_I(P12_DIR_OUT_I), .VNET_PRESENT_I(VNET_PRESENT_I), .P12_OE_O(P12_OE_O),
    .P13_ALT_I(P13_ALT_I), .TIMER8_OUT_A_I(TIMER8_OUT_A_I), .P13_OUT_O(P13_OUT_O),
    .P13_OE_O(P13_OE_O), .SYNTH_MODE_SELECT_REG_I(SYNTH_MODE_SELECT_REG_I),
    .LOW_BAND_PULLDOWN_O(LOW_BAND_PULLDOWN_O), .HIGH_BAND_PULLDOWN_O(HIGH_BAND_PULLDOWN_O),
    .PHASE_UP_I(PHASE_UP_I), .PHASE_DN_I(PHASE_DN_I),
    .CHARGE_PUMP_OUT_A_O(CHARGE_PUMP_OUT_A_O), .SYS_RESET_O(SYS_RESET_O)
);

/* File: port_pin_function_select_tb.sv */
`timescale 1ns/10ps
module port_pin_function_select_tb;
    import pin_mux_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [39:0] latch, dir, alt, ext, eoe, eout, epin;
    logic [7:0] l13, a13, syn;
    logic [12:0] m;
    logic lo_act, hi_act;
    wire [39:0] oe_w, out_w, rd_w, pin;
    wire [7:0] o13, oe13;
    wire [1:0] cpa, cpb;
    wire sdi, sci, arx, mwc, bbc, vrx, lo_o, hi_o, lpd, hpd, sysr;
    int n_fail = 0;
    int n_tests = 0;
    int seed = 32'he264efca;

    port_pin_function_select dut (
        .CLK_I(clk), .RST_B_I(rst_b),
        .P4_IN_I(pin[7:0]), .P4_LATCH_I(latch[7:0]), .P4_DIR_OUT_I(dir[0]),
        .P4_OUT_O(out_w[7:0]), .P4_OE_O(oe_w[7:0]), .P4_RD_O(rd_w[7:0]),
        .P5_IN_I(pin[15:8]), .P5_LATCH_I(latch[15:8]), .P5_DIR_OUT_I(dir[15:8]),
        .P5_OUT_O(out_w[15:8]), .P5_OE_O(oe_w[15:8]), .P5_RD_O(rd_w[15:8]),
        .P6_IN_I(pin[23:16]), .P6_LATCH_I(latch[23:16]), .P6_DIR_OUT_I(dir[23:16]),
        .P6_OUT_O(out_w[23:16]), .P6_OE_O(oe_w[23:16]), .P6_RD_O(rd_w[23:16]),
        .P7_IN_I(pin[31:24]), .P7_LATCH_I(latch[31:24]), .P7_DIR_OUT_I(dir[31:24]),
        .P7_ALT_I(alt[31:24]), .SERIAL3_DATA_OUT_I(m[0]), .SERIAL3_CLOCK_OUT_I(m[1]),
        .SERIAL3_CLOCK_OE_I(m[2]), .ASYNC_TRANSMIT_I(m[3]),
        .P7_OUT_O(out_w[31:24]), .P7_OE_O(oe_w[31:24]), .P7_RD_O(rd_w[31:24]),
        .SERIAL3_DATA_IN_O(sdi), .SERIAL3_CLOCK_IN_O(sci), .ASYNC_RECEIVE_O(arx),
        .P10_IN_I(pin[34:32]), .P10_LATCH_I(latch[34:32]), .P10_DIR_OUT_I(dir[34:32]),
        .P10_ALT_I(alt[34:32]), .MW_SRC_BB_I(m[4]),
        .P10_OUT_O(out_w[34:32]), .P10_OE_O(oe_w[34:32]), .P10_RD_O(rd_w[34:32]),
        .MW_IF_COUNTER_IN_O(mwc), .BB_IF_COUNTER_IN_O(bbc),
        .P12_IN_I(pin[39:35]), .P12_LATCH_I(latch[39:35]), .P12_DIR_OUT_I(dir[39:35]),
        .P12_ALT_I(alt[39:35]), .VNET_PRESENT_I(m[5]), .VNET_TRANSMIT_I(m[6]),
        .P12_OUT_O(out_w[39:35]), .P12_OE_O(oe_w[39:35]), .P12_RD_O(rd_w[39:35]),
        .VNET_RECEIVE_O(vrx), .P13_LATCH_I(l13), .P13_ALT_I(a13),
        .TIMER8_OUT_A_I(m[7]), .TIMER8_OUT_B_I(m[8]), .P13_OUT_O(o13), .P13_OE_O(oe13),
        .SYNTH_MODE_SELECT_REG_I(syn), .LOW_BAND_OSC_IN_I(m[9]), .HIGH_BAND_OSC_IN_I(m[10]),
        .PHASE_UP_I(m[11]), .PHASE_DN_I(m[12]), .LOW_BAND_OSC_O(lo_o), .HIGH_BAND_OSC_O(hi_o),
        .LOW_BAND_PULLDOWN_O(lpd), .HIGH_BAND_PULLDOWN_O(hpd),
        .CHARGE_PUMP_OUT_A_O(cpa), .CHARGE_PUMP_OUT_B_O(cpb), .SYS_RESET_O(sysr)
    );

    pin_board brd (.oe_i(oe_w), .out_i(out_w), .ext_i(ext), .pin_o(pin));

    initial forever #20 clk = ~clk;

    task automatic summarize;
        if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic model;
        eoe = {dir[39:8], {8{dir[0]}}} & ~(alt & (m[5] ? 40'hFFFFFFFFFF : 40'h07FFFFFFFF));
        eout = latch & eoe;
        if (alt[25]) {eoe[25], eout[25]} = {1'b1, m[0]};
        if (alt[26]) {eoe[26], eout[26]} = {m[2], m[1]};
        if (alt[29]) {eoe[29], eout[29]} = {1'b1, m[3]};
        if (m[5] && alt[35]) {eoe[35], eout[35]} = {1'b1, m[6]};
        epin = (eoe & eout) | (~eoe & ext);
        lo_act = (syn[1:0] == SYN_HF || syn[1:0] == SYN_MF) && syn[2];
        hi_act = syn[1:0] == SYN_FM && syn[3];
    endtask

    task automatic check_all;
        model();
        cmp({oe_w[7:0], out_w[7:0], rd_w[7:0]}, {eoe[7:0], eout[7:0], epin[7:0]});
        cmp({oe_w[15:8], out_w[15:8], rd_w[15:8]}, {eoe[15:8], eout[15:8], epin[15:8]});
        cmp({oe_w[23:16], out_w[23:16], rd_w[23:16]}, {eoe[23:16], eout[23:16], epin[23:16]});
        cmp({oe_w[31:24], out_w[31:24], rd_w[31:24], sdi, sci, arx}, {eoe[31:24], eout[31:24],
            epin[31:24], alt[24] & epin[24], alt[26] & epin[26], ~alt[28] | epin[28]});
        cmp({oe_w[34:32], out_w[34:32], rd_w[34:32]}, {eoe[34:32], eout[34:32], epin[34:32]});
        cmp({mwc, bbc}, {m[4] ? alt[34] & epin[34] : alt[33] & epin[33], alt[34] & epin[34]});
        cmp({oe_w[39:35], out_w[39:35], rd_w[39:35], vrx},
            {eoe[39:35], eout[39:35], epin[39:35], ~(m[5] & alt[36]) | epin[36]});
        cmp({o13, oe13}, {8'h00, ~((l13 & ~a13) | (a13 & {6'h00, m[8], m[7]}))});
        cmp({lo_o, lpd}, {lo_act & m[9], ~syn[2]});
        cmp({hi_o, hpd}, {hi_act & m[10], ~syn[3]});
        cmp({cpa, cpb}, {m[11] ^ m[12], m[11], m[11] ^ m[12], m[11]});
        cmp(sysr, 1'b0);
    endtask

    task automatic stim(input int i);
        @(negedge clk);
        latch = 40'({$random(seed), $random(seed)});
        dir = 40'({$random(seed), $random(seed)});
        ext = 40'({$random(seed), $random(seed)});
        alt = 40'({$random(seed), $random(seed)}) & 40'h1E37000000;
        {l13, a13, m} = 29'($random(seed));
        a13 = a13 & 8'h03;
        // release bits walked through every mode
        syn = {4'($random(seed)), 4'(i)};
    endtask

    initial begin
        {latch, dir, alt, ext, l13, a13, syn, m} = '0;
        repeat (10) @(negedge clk);
        cmp(oe_w, '0);
        cmp(out_w, '0);
        cmp({oe13, lpd, hpd, arx, vrx, sysr}, 13'h001F);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        {latch[15:8], dir[15:8], dir[0]} = {8'hFF, 8'h01, 1'b1};
        @(negedge clk);
        cmp({oe_w[15:0], out_w[15:8]}, 24'h01FF01);
        repeat (2) begin
            for (int i = 0; i < 200; i++) begin
                stim(i);
                repeat (6) @(negedge clk);
                check_all();
            end
            // mid-run reset with busy inputs
            rst_b = 1'b0;
            @(negedge clk);
            cmp({oe_w, oe13}, '0);
            cmp(sysr, 1'b1);
            rst_b = 1'b1;
        end
        summarize();
    end

    initial begin
        repeat (6000) @(posedge clk);
        n_fail++;
        summarize();
    end
endmodule // port_pin_function_select_tb
